/* inc/mop_defs.vh */
`ifndef MOP_DEFS_VH
`define MOP_DEFS_VH

// Command codes
`define MOP_CMD_MISC            8'hed
`define MOP_CMD_PREC            8'hee

// Miscellaneous options fields
`define MOP_BIT_PEC_REQ         15
`define MOP_BIT_SHDN_RELOAD     14
`define MOP_BIT_FLT_RELOAD      13
`define MOP_BIT_PIN_ROLE        12
`define MOP_BIT_PULLUP_N        3
`define MOP_BIT_CNT_RECOVER     2
`define MOP_RES_HI              1
`define MOP_RES_LO              0

// Precedence fields
`define MOP_BIT_STACK           12
`define MOP_BIT_SYNC            11
`define MOP_BIT_COMP            9
`define MOP_BIT_ADDR            8
`define MOP_BIT_ILV             5
`define MOP_BIT_TON             3
`define MOP_BIT_IOC             2
`define MOP_BIT_SW_RATE         1
`define MOP_BIT_OUT_VOLT        0

// Resolution codes and widths
`define MOP_RES_12              2'h0
`define MOP_RES_10              2'h1
`define MOP_RES_8               2'h2
`define MOP_RES_6               2'h3
`define MOP_W_12                4'hc
`define MOP_W_10                4'ha
`define MOP_W_8                 4'h8
`define MOP_W_6                 4'h6

// Widths and constants
`define MOP_NSEL                9
`define MOP_ZERO16              16'h0000
`define MOP_ZERO8               8'h00
`define MOP_ZERO9               9'h000
`define MOP_CNT_MAX             8'hff
`define MOP_NVM_NONE            2'h0
`define MOP_NVM_BOTH            2'h3
`define MOP_ONE8                8'h01
`define MOP_NVM_SEL_MISC        1'b0
`define MOP_NVM_SEL_PREC        1'b1

`endif

/* logic/mop_fault_counter.v */
`timescale 1ns/10ps
`include "mop_defs.vh"

module mop_fault_counter (
    // Clock and reset
    input  wire       i_sys_clk,
    input  wire       i_reset_n,
    // Control
    input  wire       i_clear_mode,
    input  wire       i_pwm_tick,
    input  wire       i_fault,
    // Count
    output reg  [7:0] o_count
);

    ////////////////////////////////////////////////////////////////////////////
    // Counter
    always @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_count <= `MOP_ZERO8;
        end else if (i_pwm_tick) begin
            if (i_fault) begin
                if (o_count != `MOP_CNT_MAX) begin
                    o_count <= o_count + `MOP_ONE8;
                end
            end else if (i_clear_mode) begin
                o_count <= `MOP_ZERO8;
            end else if (o_count != `MOP_ZERO8) begin
                o_count <= o_count - `MOP_ONE8;
            end
        end
    end

endmodule

/* logic/mop_option_regs.v */
// Summary of operation
// - Check byte required when bit fifteen set
// - Shutdown reloads setpoint with boot voltage
// - Fault retry restart reloads boot voltage
// - Bit twelve picks power-good or reset role
// - Bit three low enables reset-role pullup
// - Bit two picks decrement or clear recovery
// - Two-bit field selects converter resolution
// - Override bits keep pin-programmed values
// - Pins sampled at power-on only
// - Bit twelve selects stacking source
// - Bit eleven selects synchronization source
// - Bit nine selects compensation source
// - Bit eight selects bus address source
// - Bit five selects interleave source
// - Bit three selects rise time source
// - Bit two selects overcurrent limits source
// - Bit one selects switching rate source
// - Bit zero selects output voltage source
// - Selection applied at reset and restore
`timescale 1ns/10ps
`include "mop_defs.vh"

module mop_option_regs (
    // Clock and reset
    input  wire        i_sys_clk,
    input  wire        i_reset_n,
    // Command port
    input  wire        i_cmd_valid,
    input  wire [7:0]  i_cmd_code,
    input  wire        i_cmd_write,
    input  wire [15:0] i_cmd_wdata,
    input  wire        i_cmd_has_pec,
    output reg  [15:0] o_cmd_rdata,
    output reg         o_cmd_ack,
    output reg         o_pec_error,
    // Nonvolatile store
    input  wire        i_nvm_valid,
    input  wire        i_nvm_sel,
    input  wire [15:0] i_nvm_data,
    input  wire        i_restore_user_all,
    // Configuration pins and stored values
    input  wire [8:0]  i_pin_detect,
    input  wire [8:0]  i_stored_val,
    output reg  [8:0]  o_setting_val,
    output reg         o_setting_load,
    output reg  [8:0]  o_pin_latched,
    // Setpoint control
    input  wire        i_shutdown,
    input  wire        i_fault_restart,
    input  wire        i_retry_mode,
    output reg         o_setpoint_reload,
    // Shared status pin
    input  wire        i_power_good,
    input  wire        i_reset_assert,
    output reg         o_status_pin_o,
    output reg         o_status_pin_oe,
    output reg         o_status_pullup_en,
    // Fault counter and converter
    input  wire        i_pwm_tick,
    input  wire        i_fault,
    output reg  [7:0]  o_fault_count,
    output reg  [3:0]  o_adc_width,
    output reg         o_ready
);

    ////////////////////////////////////////////////////////////////////////////
    // State encoding
    localparam [2:0] ST_BOOT    = 3'h1;
    localparam [2:0] ST_RESOLVE = 3'h2;
    localparam [2:0] ST_RUN     = 3'h4;

    reg  [2:0]  state_reg;
    reg  [2:0]  state_next;
    reg  [15:0] misc_option_settings_reg;
    reg  [15:0] pin_value_precedence_reg;
    reg  [1:0]  nvm_got_reg;
    reg         pins_taken_reg;
    reg  [8:0]  pin_latched_reg;
    wire [8:0]  use_pin;
    wire [7:0]  count_w;

    ////////////////////////////////////////////////////////////////////////////
    // Functions
    function [3:0] res_width;
        input [1:0] code;
        begin
            case (code)
                `MOP_RES_12: res_width = `MOP_W_12;
                `MOP_RES_10: res_width = `MOP_W_10;
                `MOP_RES_8:  res_width = `MOP_W_8;
                default:     res_width = `MOP_W_6;
            endcase
        end
    endfunction

    function is_ours;
        input [7:0] code;
        begin
            is_ours = (code == `MOP_CMD_MISC) || (code == `MOP_CMD_PREC);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Override bit map per setting group
    assign use_pin[0] = pin_value_precedence_reg[`MOP_BIT_OUT_VOLT];
    assign use_pin[1] = pin_value_precedence_reg[`MOP_BIT_SW_RATE];
    assign use_pin[2] = pin_value_precedence_reg[`MOP_BIT_IOC];
    assign use_pin[3] = pin_value_precedence_reg[`MOP_BIT_TON];
    assign use_pin[4] = pin_value_precedence_reg[`MOP_BIT_ILV];
    assign use_pin[5] = pin_value_precedence_reg[`MOP_BIT_ADDR];
    assign use_pin[6] = pin_value_precedence_reg[`MOP_BIT_COMP];
    assign use_pin[7] = pin_value_precedence_reg[`MOP_BIT_SYNC];
    assign use_pin[8] = pin_value_precedence_reg[`MOP_BIT_STACK];

    ////////////////////////////////////////////////////////////////////////////
    // Boot sequencer
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_BOOT: begin
                if (nvm_got_reg == `MOP_NVM_BOTH) begin
                    state_next = ST_RESOLVE;
                end
            end
            ST_RESOLVE: begin
                state_next = ST_RUN;
            end
            ST_RUN: begin
                if (i_restore_user_all) begin
                    state_next = ST_BOOT;
                end
            end
            default: begin
                state_next = ST_BOOT;
            end
        endcase
    end

    always @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_reg <= ST_BOOT;
            nvm_got_reg <= `MOP_NVM_NONE;
        end else begin
            state_reg <= state_next;
            if (state_reg == ST_RUN && i_restore_user_all) begin
                nvm_got_reg <= `MOP_NVM_NONE;
            end else if (i_nvm_valid && state_reg == ST_BOOT) begin
                if (i_nvm_sel == `MOP_NVM_SEL_PREC) begin
                    nvm_got_reg[1] <= 1'b1;
                end else begin
                    nvm_got_reg[0] <= 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin sampling once after power-on release
    always @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pins_taken_reg <= 1'b0;
            pin_latched_reg <= `MOP_ZERO9;
        end else if (!pins_taken_reg) begin
            pins_taken_reg <= 1'b1;
            pin_latched_reg <= i_pin_detect;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers and command port
    always @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            misc_option_settings_reg <= `MOP_ZERO16;
            pin_value_precedence_reg <= `MOP_ZERO16;
            o_cmd_rdata <= `MOP_ZERO16;
            o_cmd_ack <= 1'b0;
            o_pec_error <= 1'b0;
        end else begin
            o_cmd_ack <= 1'b0;
            o_pec_error <= 1'b0;
            if (i_nvm_valid && state_reg == ST_BOOT) begin
                if (i_nvm_sel == `MOP_NVM_SEL_PREC) begin
                    pin_value_precedence_reg <= i_nvm_data;
                end else begin
                    misc_option_settings_reg <= i_nvm_data;
                end
            end else if (i_cmd_valid && is_ours(i_cmd_code)) begin
                if (misc_option_settings_reg[`MOP_BIT_PEC_REQ] && !i_cmd_has_pec) begin
                    o_pec_error <= 1'b1;
                end else begin
                    o_cmd_ack <= 1'b1;
                    if (i_cmd_write) begin
                        if (i_cmd_code == `MOP_CMD_PREC) begin
                            pin_value_precedence_reg <= i_cmd_wdata;
                        end else begin
                            misc_option_settings_reg <= i_cmd_wdata;
                        end
                    end else if (i_cmd_code == `MOP_CMD_PREC) begin
                        o_cmd_rdata <= pin_value_precedence_reg;
                    end else begin
                        o_cmd_rdata <= misc_option_settings_reg;
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Setting source selection
    genvar g;
    generate
        for (g = 0; g < `MOP_NSEL; g = g + 1) begin : g_sel
            always @(posedge i_sys_clk or negedge i_reset_n) begin
                if (!i_reset_n) begin
                    o_setting_val[g] <= 1'b0;
                end else if (state_reg == ST_RESOLVE) begin
                    o_setting_val[g] <= use_pin[g] ? pin_latched_reg[g] : i_stored_val[g];
                end
            end
        end
    endgenerate

    always @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_setting_load <= 1'b0;
            o_ready <= 1'b0;
            o_pin_latched <= `MOP_ZERO9;
        end else begin
            o_setting_load <= (state_reg == ST_RESOLVE);
            o_ready <= (state_reg == ST_RUN);
            o_pin_latched <= pin_latched_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Setpoint reload and status pin
    always @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_setpoint_reload <= 1'b0;
            o_status_pin_o <= 1'b0;
            o_status_pin_oe <= 1'b1;
            o_status_pullup_en <= 1'b0;
        end else begin
            o_setpoint_reload <=
                (i_shutdown && misc_option_settings_reg[`MOP_BIT_SHDN_RELOAD]) ||
                (i_fault_restart && i_retry_mode &&
                 misc_option_settings_reg[`MOP_BIT_FLT_RELOAD]);
            o_status_pin_o <= 1'b0;
            if (misc_option_settings_reg[`MOP_BIT_PIN_ROLE]) begin
                o_status_pin_oe <= i_reset_assert;
                o_status_pullup_en <= !misc_option_settings_reg[`MOP_BIT_PULLUP_N];
            end else begin
                o_status_pin_oe <= !i_power_good;
                o_status_pullup_en <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Fault counter and resolution
    mop_fault_counter u_fault_counter (
        .i_sys_clk    (i_sys_clk),
        .i_reset_n    (i_reset_n),
        .i_clear_mode (misc_option_settings_reg[`MOP_BIT_CNT_RECOVER]),
        .i_pwm_tick   (i_pwm_tick),
        .i_fault      (i_fault),
        .o_count      (count_w)
    );

    always @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_fault_count <= `MOP_ZERO8;
            o_adc_width <= `MOP_W_12;
        end else begin
            o_fault_count <= count_w;
            o_adc_width <= res_width(
                misc_option_settings_reg[`MOP_RES_HI:`MOP_RES_LO]);
        end
    end

endmodule

/* verification/mop_option_regs_checker.sv */
`timescale 1ns/10ps
module mop_option_regs_checker (
    // Clock, reset and requests
    input wire        i_sys_clk,
    input wire        i_reset_n,
    input wire        i_cmd_valid,
    input wire [7:0]  i_cmd_code,
    input wire        i_cmd_has_pec,
    input wire        i_restore_user_all,
    input wire        i_shutdown,
    input wire        i_fault_restart,
    input wire        i_retry_mode,
    input wire        i_pwm_tick,
    // Watched outputs
    input wire        o_cmd_ack,
    input wire        o_pec_error,
    input wire        o_setting_load,
    input wire [8:0]  o_pin_latched,
    input wire        o_setpoint_reload,
    input wire        o_status_pin_o,
    input wire [7:0]  o_fault_count,
    input wire [3:0]  o_adc_width,
    input wire        o_ready
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_reset_n);
    wire known = (i_cmd_code == 8'hed) || (i_cmd_code == 8'hee);

    a_ack_cause: assert property (
        o_cmd_ack |-> $past(i_cmd_valid) && $past(known) && !o_pec_error)
        else $error("ack without command");
    a_pec_cause: assert property (
        o_pec_error |-> $past(i_cmd_valid) && $past(known) && !$past(i_cmd_has_pec))
        else $error("check byte error without cause");
    a_pec_pass: assert property (
        i_cmd_valid && known && i_cmd_has_pec && o_ready && !i_restore_user_all |=> o_cmd_ack)
        else $error("command with check byte not answered");
    a_reload_cause: assert property (
        o_setpoint_reload |-> $past(i_shutdown) || ($past(i_fault_restart) && $past(i_retry_mode)))
        else $error("setpoint reload without cause");
    a_pin_drive: assert property (
        o_status_pin_o == 1'b0)
        else $error("status pin driven high");
    a_width_legal: assert property (
        o_adc_width inside {4'hc, 4'ha, 4'h8, 4'h6})
        else $error("illegal converter width");
    a_pins_held: assert property (
        $past(o_ready) |-> $stable(o_pin_latched))
        else $error("pin values changed in run");
    a_load_ready: assert property (
        o_setting_load |-> ##[0:2] o_ready)
        else $error("no ready after settings load");
    a_count_tick: assert property (
        $changed(o_fault_count) |-> $past(i_pwm_tick, 1) || $past(i_pwm_tick, 2))
        else $error("fault count moved without tick");
endmodule

bind mop_option_regs mop_option_regs_checker u_chk (.*);

/* verification/mop_nvm_model.sv */
`timescale 1ns/10ps
module mop_nvm_model (
    // Clock, reset and restore
    input  wire        i_sys_clk,
    input  wire        i_reset_n,
    input  wire        i_restore_user_all,
    // Stored contents
    input  wire [15:0] i_misc_word,
    input  wire [15:0] i_prec_word,
    // Store words
    output reg         o_nvm_valid,
    output reg         o_nvm_sel,
    output reg  [15:0] o_nvm_data
);
    reg [2:0] step_reg;
    // store words at power-up and restore
    always @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            step_reg    <= 3'h1;
            o_nvm_valid <= 1'b0;
            o_nvm_sel   <= 1'b0;
            o_nvm_data  <= 16'h0000;
        end else begin
            if (i_restore_user_all)
                step_reg <= 3'h1;
            else
                step_reg <= (step_reg == 3'h0 || step_reg == 3'h4) ? 3'h0 : step_reg + 3'h1;
            o_nvm_valid <= (step_reg == 3'h2) || (step_reg == 3'h4);
            o_nvm_sel   <= (step_reg == 3'h4);
            o_nvm_data  <= (step_reg == 3'h2) ? i_misc_word :
                           (step_reg == 3'h4) ? i_prec_word : ~o_nvm_data;
        end
    end
endmodule

/* verification/test_misc_option_settings_pin_override_regs.sv */
`timescale 1ns/10ps
`define CHK(a, b) begin samples_checked = samples_checked + 1; if ((a) !== (b)) begin \
    error_cnt = error_cnt + 1; $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module test_misc_option_settings_pin_override_regs;
    localparam [8:0]  PINS = 9'h0b5;
    localparam [87:0] ROWS = {16'h100b, 4'h6, 2'h0, 16'h1002, 4'h8, 2'h2,
                              16'h0001, 4'ha, 2'h1, 16'h0000, 4'hc, 2'h1};
    localparam [79:0] RLD  = {16'h2000, 4'h4, 16'h2000, 4'h7, 16'h0000, 4'h8, 16'h4000, 4'h9};
    localparam [47:0] OVR  = {16'h0905, 16'h0000, 16'h1b2f};
    reg i_sys_clk = 0, i_reset_n = 0, i_cmd_valid = 0, i_cmd_write = 0, i_cmd_has_pec = 0;
    reg i_restore_user_all = 0, i_shutdown = 0, i_fault_restart = 0, i_retry_mode = 0;
    reg i_power_good = 0, i_reset_assert = 0, i_pwm_tick = 0, i_fault = 0;
    reg [7:0]  i_cmd_code = 8'h00;
    reg [15:0] i_cmd_wdata = 16'h0000, misc_word = 16'h0001, prec_word = 16'h0000, rd_s;
    reg [8:0]  i_pin_detect = PINS, i_stored_val = 9'h14a;
    reg        ack_s, err_s, seen;
    reg [21:0] r;
    integer    error_cnt = 0, samples_checked = 0, cyc = 0, i;
    wire       i_nvm_valid, i_nvm_sel, o_cmd_ack, o_pec_error, o_setting_load, o_ready;
    wire       o_setpoint_reload, o_status_pin_o, o_status_pin_oe, o_status_pullup_en;
    wire [15:0] i_nvm_data, o_cmd_rdata;
    wire [8:0]  o_setting_val, o_pin_latched;
    wire [7:0]  o_fault_count;
    wire [3:0]  o_adc_width;

    mop_option_regs uut (.*);
    mop_nvm_model u_nvm (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n),
        .i_restore_user_all(i_restore_user_all), .i_misc_word(misc_word),
        .i_prec_word(prec_word), .o_nvm_valid(i_nvm_valid), .o_nvm_sel(i_nvm_sel),
        .o_nvm_data(i_nvm_data));

    always #4 i_sys_clk = ~i_sys_clk;
    always @(posedge i_sys_clk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            error_cnt = error_cnt + 1;
            summarize;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    task summarize;
        begin
            $display("errors %0d checks %0d", error_cnt, samples_checked);
            if (error_cnt == 0 && samples_checked > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask
    task cmd(input [7:0] code, input wr, input [15:0] d, input pec);
        begin
            @(posedge i_sys_clk);
            #1;
            {i_cmd_valid, i_cmd_code, i_cmd_write} = {1'b1, code, wr};
            {i_cmd_wdata, i_cmd_has_pec} = {d, pec};
            @(posedge i_sys_clk);
            #1;
            i_cmd_valid = 0;
            {ack_s, err_s, rd_s} = {o_cmd_ack, o_pec_error, o_cmd_rdata};
        end
    endtask
    task wait_load;
        integer k;
        begin
            k = 0;
            while (o_setting_load !== 1'b1 && k < 100) begin
                @(posedge i_sys_clk);
                #1;
                k = k + 1;
            end
            `CHK(o_setting_load, 1'b1)
            repeat (2) @(posedge i_sys_clk);
            #1;
            `CHK(o_ready, 1'b1)
        end
    endtask
    task tick(input f);
        begin
            @(posedge i_sys_clk);
            #1;
            {i_pwm_tick, i_fault} = {1'b1, f};
            @(posedge i_sys_clk);
            #1;
            i_pwm_tick = 0;
            repeat (3) @(posedge i_sys_clk);
            #1;
        end
    endtask
    function [8:0] pick(input [15:0] p);
        reg [8:0] m;
        begin
            m = {p[12], p[11], p[9], p[8], p[5], p[3], p[2], p[1], p[0]};
            pick = (PINS & m) | (i_stored_val & ~m);
        end
    endfunction
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge i_sys_clk);
        #1;
        `CHK(o_adc_width, 4'hc)
        i_reset_n = 1;
        wait_load;
        cmd(8'hed, 0, 16'h0000, 1);
        `CHK(rd_s, 16'h0001)
        i_pin_detect = 9'h1ff;
        for (i = 0; i < 4; i = i + 1) begin
            r = ROWS[i*22 +: 22];
            cmd(8'hed, 1, r[21:6], 1);
            cmd(8'hed, 0, 16'h0000, 1);
            `CHK(rd_s, r[21:6])
            `CHK(o_adc_width, r[5:2])
            `CHK(o_status_pullup_en, r[1])
            `CHK(o_status_pin_oe, r[0])
        end
        i_reset_assert = 1;
        tick(0);
        `CHK(o_status_pin_oe, 1'b1)
        for (i = 0; i < 4; i = i + 1) begin
            cmd(8'hed, 1, RLD[i*20+4 +: 16], 1);
            @(posedge i_sys_clk);
            #1;
            {i_shutdown, i_fault_restart, i_retry_mode} = RLD[i*20+1 +: 3];
            @(posedge i_sys_clk);
            #1;
            {i_shutdown, i_fault_restart, i_retry_mode} = 3'h0;
            seen = o_setpoint_reload;
            @(posedge i_sys_clk);
            #1;
            seen = seen | o_setpoint_reload;
            `CHK(seen, RLD[i*20])
        end
        i_power_good = 1;
        repeat (2) @(posedge i_sys_clk);
        #1;
        `CHK(o_status_pin_oe, 1'b0)
        `CHK(o_status_pullup_en, 1'b0)
        cmd(8'hed, 1, 16'h8000, 1);
        cmd(8'hed, 1, 16'h8003, 0);
        `CHK({ack_s, err_s}, 2'h1)
        cmd(8'hed, 0, 16'h0000, 1);
        `CHK(rd_s, 16'h8000)
        cmd(8'hed, 1, 16'h0000, 1);
        cmd(8'hed, 0, 16'h0000, 0);
        `CHK({ack_s, err_s}, 2'h2)
        cmd(8'hef, 1, 16'h0000, 1);
        `CHK(ack_s, 1'b0)
        tick(1);
        tick(1);
        tick(1);
        `CHK(o_fault_count, 8'h03)
        tick(0);
        `CHK(o_fault_count, 8'h02)
        cmd(8'hed, 1, 16'h0004, 1);
        tick(0);
        `CHK(o_fault_count, 8'h00)
        for (i = 0; i < 3; i = i + 1) begin
            prec_word = OVR[i*16 +: 16];
            @(posedge i_sys_clk);
            #1;
            i_restore_user_all = 1;
            @(posedge i_sys_clk);
            #1;
            i_restore_user_all = 0;
            wait_load;
            `CHK(o_setting_val, pick(prec_word))
            `CHK(o_pin_latched, PINS)
            cmd(8'hee, 0, 16'h0000, 1);
            `CHK(rd_s, prec_word)
        end
        summarize;
    end
endmodule
